//--- bench/alfio_core_bench.sv
`timescale 1ns/100ps
module alfio_core_bench;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic req_valid = 1'b0;
	alfio_pkg::alfio_req_t req = '0;
	logic req_ready;
	logic [15:0] result;
	logic result_valid;
	logic [7:0] flag_register;
	logic [7:0] io_rdata;
	logic [7:0] osc_trim;
	logic [7:0] debug_data;
	logic [5:0] io_addr = '0;
	logic io_we = 1'b0;
	logic io_re = 1'b0;
	logic [7:0] io_wdata = '0;
	logic bit_valid = 1'b0;
	logic [4:0] bit_addr = '0;
	logic [2:0] bit_num = '0;
	logic bit_set = 1'b0;
	logic [7:0] event_in = '0;
	logic debug_enable_fuse = 1'b0;
	int n_fail = 0;
	int total_checks = 0;
	logic [23:0] e;
	logic [7:0] fv;

	alfio_core dut (.clk(clk), .rst_n(rst_n), .req_valid(req_valid),
		.req(req), .req_ready(req_ready), .result(result),
		.result_valid(result_valid), .flag_register(flag_register),
		.io_addr(io_addr), .io_we(io_we), .io_re(io_re),
		.io_wdata(io_wdata), .io_rdata(io_rdata), .bit_valid(bit_valid),
		.bit_addr(bit_addr), .bit_num(bit_num), .bit_set(bit_set),
		.event_in(event_in), .debug_enable_fuse(debug_enable_fuse),
		.osc_trim(osc_trim), .debug_data(debug_data));

	always #20 clk = ~clk;

	// ----------------------------------------------------------------
	// Reference model and access tasks
	// ----------------------------------------------------------------
	// Operation index follows the enum order; returns {flags, result}.
	function automatic logic [23:0] model(input int i, input logic [7:0] a,
		input logic [7:0] b, input logic [7:0] ah, input logic [7:0] f);
		logic [16:0] w;
		logic [8:0] r;
		logic [4:0] h;
		logic c;
		c = f[0] & (i == 1 || i == 4 || i == 5);
		if (i >= 10) begin
			w = (i == 10) ? {ah, a} + b : {ah, a} - b;
			f[0] = (i == 10) ? ah[7] & ~w[15] : w[15] & ~ah[7];
			f[3] = (i == 10) ? ~ah[7] & w[15] : ah[7] & ~w[15];
			f[1] = w[15:0] == 16'h0000;
			f[2] = w[15];
			f[4] = f[2] ^ f[3];
			return {f, w[15:0]};
		end
		if (i >= 6) begin
			r = (i >= 8) ? {1'b0, a | b} : {1'b0, a & b};
			f[3] = 1'b0;
		end else if (i < 2) begin
			r = a + b + c;
			h = a[3:0] + b[3:0] + c;
			f[3] = (a[7] & b[7] & ~r[7]) | (~a[7] & ~b[7] & r[7]);
		end else begin
			r = a - b - c;
			h = a[3:0] - b[3:0] - c;
			f[3] = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
		end
		if (i < 6) begin
			f[0] = r[8];
			f[5] = h[4];
		end
		f[1] = r[7:0] == 8'h00;
		f[2] = r[7];
		return {f, 8'h00, r[7:0]};
	endfunction

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask

	// Every mapped register defines all eight bits, so none is reserved.
	task automatic io_wr(input logic [5:0] ad, input logic [7:0] d);
		@(posedge clk);
		io_we <= 1'b1;
		io_addr <= ad;
		io_wdata <= d;
		@(posedge clk);
		io_we <= 1'b0;
		#1;
	endtask

	task automatic io_rd(input logic [5:0] ad, input logic [7:0] exp);
		@(posedge clk);
		io_re <= 1'b1;
		io_addr <= ad;
		@(posedge clk);
		io_re <= 1'b0;
		#1;
		chk({8'h00, io_rdata}, {8'h00, exp});
	endtask

	task automatic bit_op(input logic [4:0] ad, input logic [2:0] n,
		input logic s);
		@(posedge clk);
		bit_valid <= 1'b1;
		bit_addr <= ad;
		bit_num <= n;
		bit_set <= s;
		@(posedge clk);
		bit_valid <= 1'b0;
		#1;
	endtask

	task automatic pulse(input logic [7:0] v);
		@(posedge clk);
		event_in <= v;
		@(posedge clk);
		event_in <= 8'h00;
	endtask

	// The result must stand one edge after a byte op and two after a word op.
	task automatic do_op(input int i, input logic [7:0] a, input logic [7:0] b,
		input logic [7:0] ah, input logic [7:0] f);
		e = model(i, a, b, ah, f);
		@(posedge clk);
		req_valid <= 1'b1;
		req <= '{alfio_pkg::alfio_op_t'(i), a, b, ah};
		@(posedge clk);
		req_valid <= 1'b0;
		#1;
		if (i >= 10) begin
			chk({15'h0000, req_ready}, 16'h0000);
			@(posedge clk);
			#1;
		end
		chk({15'h0000, result_valid}, 16'h0001);
		chk(result, e[15:0]);
		chk({8'h00, flag_register}, {8'h00, e[23:16]});
	endtask

	task automatic end_of_test();
		$display("checks %0d failures %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		#1;
		chk({flag_register, osc_trim}, {alfio_pkg::FLAGS_RESET,
			alfio_pkg::TRIM_RESET});
		io_rd(alfio_pkg::IO_FLAGS_ADDR, alfio_pkg::FLAGS_RESET);
		$display("test reset done");
		// Each op runs with all flags clear and all set, so kept bits show.
		for (int i = 0; i < 12; i++) begin
			for (int k = 0; k < 2; k++) begin
				fv = k ? 8'hFF : 8'h00;
				io_wr(alfio_pkg::IO_FLAGS_ADDR, fv);
				chk({8'h00, flag_register}, {8'h00, fv});
				do_op(i, 8'h3C + 8'(i * 37), 8'hC5 ^ 8'(i * 29), 8'h7F, fv);
			end
		end
		do_op(10, 8'hFF, 8'h01, 8'hFF, e[23:16]);
		do_op(11, 8'h00, 8'h01, 8'h00, e[23:16]);
		$display("test datapath done");
		pulse(8'h05);
		io_rd(alfio_pkg::IO_EVT_ADDR, 8'h05);
		io_wr(alfio_pkg::IO_EVT_ADDR, 8'h04);
		io_rd(alfio_pkg::IO_EVT_ADDR, 8'h01);
		io_wr(alfio_pkg::IO_EVT_ADDR, 8'h00);
		io_rd(alfio_pkg::IO_EVT_ADDR, 8'h01);
		pulse(8'h06);
		bit_op(5'h0E, 3'h1, 1'b0);
		io_rd(alfio_pkg::IO_EVT_ADDR, 8'h02);
		bit_op(5'h0E, 3'h1, 1'b1);
		io_rd(alfio_pkg::IO_EVT_ADDR, 8'h00);
		// A new event and a clear of the same bit in one cycle: the set wins.
		@(posedge clk);
		event_in <= 8'h08;
		io_we <= 1'b1;
		io_addr <= alfio_pkg::IO_EVT_ADDR;
		io_wdata <= 8'h08;
		@(posedge clk);
		event_in <= 8'h00;
		io_we <= 1'b0;
		io_rd(alfio_pkg::IO_EVT_ADDR, 8'h08);
		io_wr(alfio_pkg::IO_FLAGS_ADDR, 8'hA5);
		bit_op(5'h1F, 3'h0, 1'b0);
		bit_op(5'h1F, 3'h1, 1'b1);
		chk({8'h00, flag_register}, 16'h00A5);
		$display("test event flags done");
		io_wr(alfio_pkg::IO_TRIM_ADDR, 8'h5A);
		chk({osc_trim, debug_data}, 16'h5A00);
		io_rd(alfio_pkg::IO_TRIM_ADDR, 8'h5A);
		@(posedge clk);
		debug_enable_fuse <= 1'b1;
		io_wr(alfio_pkg::IO_TRIM_ADDR, 8'hC3);
		chk({osc_trim, debug_data}, 16'h5AC3);
		io_rd(alfio_pkg::IO_TRIM_ADDR, 8'hC3);
		// Unmapped 0x20 is only read here; unmapped 0x1F took a bit clear and a bit set above.
		io_rd(6'h20, 8'h00);
		$display("test shared address done");
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		#1;
		chk({osc_trim, debug_data}, {alfio_pkg::TRIM_RESET,
			alfio_pkg::DEBUG_RESET});
		chk({8'h00, flag_register}, {8'h00, alfio_pkg::FLAGS_RESET});
		$display("test second reset done");
		end_of_test();
	end

	// The full sequence needs well under a thousand cycles.
	initial begin
		repeat (3000) @(posedge clk);
		n_fail++;
		end_of_test();
	end
endmodule

//--- include/alfio_pkg.sv
package alfio_pkg;

	// ----------------------------------------------------------------
	// I/O map and reset values
	// ----------------------------------------------------------------
	localparam logic [5:0] IO_EVT_ADDR = 6'h0E;
	localparam logic [5:0] IO_TRIM_ADDR = 6'h31;
	localparam logic [5:0] IO_FLAGS_ADDR = 6'h3F;
	localparam logic [7:0] FLAGS_RESET = 8'h00;
	localparam logic [7:0] TRIM_RESET = 8'h00;
	localparam logic [7:0] DEBUG_RESET = 8'h00;
	localparam logic [7:0] EVT_RESET = 8'h00;

	// ----------------------------------------------------------------
	// Flag register bit positions
	// ----------------------------------------------------------------
	localparam int FLAG_C = 0;
	localparam int FLAG_Z = 1;
	localparam int FLAG_N = 2;
	localparam int FLAG_V = 3;
	localparam int FLAG_S = 4;
	localparam int FLAG_H = 5;
	localparam int FLAG_T = 6;
	localparam int FLAG_I = 7;

	// ----------------------------------------------------------------
	// Operations and types
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		OP_ADD_REGS,
		OP_ADD_CARRY_REGS,
		OP_SUB_REGS,
		OP_SUB_IMM,
		OP_SUB_BORROW_REGS,
		OP_SUB_BORROW_IMM,
		OP_AND_REGS,
		OP_AND_IMM,
		OP_OR_REGS,
		OP_OR_IMM,
		OP_WORD_ADD_IMM,
		OP_WORD_SUB_IMM
	} alfio_op_t;

	typedef enum logic [1:0] {KIND_ADD, KIND_SUB, KIND_AND, KIND_OR} alfio_kind_t;

	typedef enum logic {ST_IDLE, ST_WORD_HI} alfio_fsm_t;

	typedef struct packed {
		alfio_op_t op;
		logic [7:0] a;
		logic [7:0] b;
		logic [7:0] a_hi;
	} alfio_req_t;

	typedef struct packed {
		logic [7:0] res;
		logic c;
		logic h;
		logic v;
		logic n;
		logic z;
	} alfio_alu_out_t;

	typedef struct packed {
		alfio_fsm_t fsm;
		logic [7:0] flags;
		logic [15:0] result;
		logic done;
		logic [7:0] lo;
		logic carry;
		logic word_sub;
		logic [7:0] a_hi;
		logic [7:0] evt;
		logic [7:0] trim;
		logic [7:0] dbg;
		logic [7:0] io_rdata;
	} alfio_state_t;

	function automatic alfio_kind_t op_kind(input alfio_op_t op);
		unique case (op)
			OP_ADD_REGS, OP_ADD_CARRY_REGS, OP_WORD_ADD_IMM: op_kind = KIND_ADD;
			OP_AND_REGS, OP_AND_IMM: op_kind = KIND_AND;
			OP_OR_REGS, OP_OR_IMM: op_kind = KIND_OR;
			default: op_kind = KIND_SUB;
		endcase
	endfunction

	function automatic logic uses_carry(input alfio_op_t op);
		uses_carry = (op == OP_ADD_CARRY_REGS) || (op == OP_SUB_BORROW_REGS) ||
			(op == OP_SUB_BORROW_IMM);
	endfunction

	function automatic logic is_word(input alfio_op_t op);
		is_word = (op == OP_WORD_ADD_IMM) || (op == OP_WORD_SUB_IMM);
	endfunction

endpackage

//--- rtl/alfio_alu.sv
`timescale 1ns/100ps
module alfio_alu (
	input wire logic [7:0] a, // Destination operand.
	input wire logic [7:0] b, // Source register or constant.
	input wire logic cin, // Carry or borrow in.
	input wire alfio_pkg::alfio_kind_t kind, // Operation class.
	output alfio_pkg::alfio_alu_out_t out // Result and raw flags.
);
	logic [8:0] full;
	logic [4:0] nib;

	always_comb begin
		full = 9'h000;
		nib = 5'h00;
		out = '0;
		unique case (kind)
			alfio_pkg::KIND_ADD: begin
				full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
				nib = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
				out.res = full[7:0];
				out.v = (a[7] == b[7]) && (full[7] != a[7]);
			end
			alfio_pkg::KIND_SUB: begin
				full = {1'b0, a} - {1'b0, b} - {8'h00, cin};
				nib = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
				out.res = full[7:0];
				out.v = (a[7] != b[7]) && (full[7] != a[7]);
			end
			alfio_pkg::KIND_AND: out.res = a & b;
			alfio_pkg::KIND_OR: out.res = a | b;
		endcase
		// Bit 8 and bit 4 are carry for add and borrow for subtract.
		out.c = full[8];
		out.h = nib[4];
		out.n = out.res[7];
		out.z = (out.res == 8'h00);
	end
endmodule

//--- rtl/alfio_core.sv
// How it works
// (RL1) Add and add-with-carry of two registers, flags Z C N V H, one clock.
// (RL2) Word add of a constant to a register pair, flags Z C N V S, two clocks.
// (RL3) Subtract register or constant, flags Z C N V H, one clock.
// (RL4) Subtract register and carry, flags Z C N V H, one clock.
// (RL5) Subtract constant and carry, write back, flags Z C N V H, one clock.
// (RL6) Word subtract of a constant from a register pair, two clocks.
// (RL7) AND with register or constant, only Z N V change, one clock.
// (RL8) OR with register or constant, only Z N V change, one clock.
// (RL9) Event flags clear on writing one; writing zero leaves them.
// (RL10) Bit set and clear rewrite the whole register, clearing set flags other than a bit being cleared.
// (RL11) Bit set and clear reach only I/O locations 0x00 to 0x1F.
// (RL12) Software writes zero to reserved bits.
// (RL13) Software never writes reserved I/O addresses; the bench sets and clears bits at unmapped 0x1F.
// (RL14) With debug fuse off, the shared address selects the trim register.
// (RL15) AND and OR clear V, take Z and N from result, keep others.
`timescale 1ns/100ps
module alfio_core (
	input wire logic clk, // Core clock.
	input wire logic rst_n, // Asynchronous reset, active low.
	input wire logic req_valid, // Operation request.
	input wire alfio_pkg::alfio_req_t req, // Operation and operands.
	output logic req_ready, // Datapath can take a request.
	output logic [15:0] result, // Last result, word in full.
	output logic result_valid, // One-cycle pulse with result.
	output logic [7:0] flag_register, // Flag register contents.
	input wire logic [5:0] io_addr, // I/O address.
	input wire logic io_we, // I/O write strobe.
	input wire logic io_re, // I/O read strobe.
	input wire logic [7:0] io_wdata, // I/O write data.
	output logic [7:0] io_rdata, // I/O read data, one cycle later.
	input wire logic bit_valid, // Single-bit set or clear request.
	input wire logic [4:0] bit_addr, // Low I/O location only.
	input wire logic [2:0] bit_num, // Bit to act on.
	input wire logic bit_set, // 1 sets, 0 clears.
	input wire logic [7:0] event_in, // Hardware event set pulses.
	input wire logic debug_enable_fuse, // High when programmed.
	output logic [7:0] osc_trim, // Oscillator trim value.
	output logic [7:0] debug_data // Debug data register.
);
	localparam alfio_pkg::alfio_state_t STATE_RESET = '{
		fsm: alfio_pkg::ST_IDLE, flags: alfio_pkg::FLAGS_RESET,
		result: 16'h0000, done: 1'b0, lo: 8'h00, carry: 1'b0,
		word_sub: 1'b0, a_hi: 8'h00, evt: alfio_pkg::EVT_RESET,
		trim: alfio_pkg::TRIM_RESET, dbg: alfio_pkg::DEBUG_RESET,
		io_rdata: 8'h00};

	alfio_pkg::alfio_state_t s;
	alfio_pkg::alfio_state_t next_s;
	alfio_pkg::alfio_alu_out_t alu;
	alfio_pkg::alfio_kind_t alu_kind;
	logic [7:0] alu_a;
	logic [7:0] alu_b;
	logic alu_cin;
	logic [7:0] evt_clr;
	logic [7:0] rmw_val;

	// ----------------------------------------------------------------
	// I/O read decode
	// ----------------------------------------------------------------
	function automatic logic [7:0] io_read(input logic [5:0] addr);
		if (addr == alfio_pkg::IO_FLAGS_ADDR)
			io_read = s.flags;
		else if (addr == alfio_pkg::IO_TRIM_ADDR)
			io_read = debug_enable_fuse ? s.dbg : s.trim;
		else if (addr == alfio_pkg::IO_EVT_ADDR)
			io_read = s.evt;
		else
			io_read = 8'h00;
	endfunction

	alfio_alu u_alu (
		.a(alu_a),
		.b(alu_b),
		.cin(alu_cin),
		.kind(alu_kind),
		.out(alu)
	);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		next_s = s;
		next_s.done = 1'b0;
		alu_a = req.a;
		alu_b = req.b;
		alu_cin = 1'b0;
		alu_kind = alfio_pkg::op_kind(req.op);
		evt_clr = 8'h00;
		rmw_val = 8'h00;
		if (s.fsm == alfio_pkg::ST_WORD_HI) begin
			// High byte takes only the carry of the low byte. [RL2] [RL6]
			alu_a = s.a_hi;
			alu_b = 8'h00;
			alu_cin = s.carry;
			alu_kind = s.word_sub ? alfio_pkg::KIND_SUB : alfio_pkg::KIND_ADD;
		end else if (alfio_pkg::uses_carry(req.op)) begin
			alu_cin = s.flags[alfio_pkg::FLAG_C]; // [RL1] [RL4] [RL5]
		end

		if (io_re)
			next_s.io_rdata = io_read(io_addr);
		if (io_we && io_addr == alfio_pkg::IO_FLAGS_ADDR)
			next_s.flags = io_wdata;
		if (io_we && io_addr == alfio_pkg::IO_TRIM_ADDR) begin
			if (debug_enable_fuse)
				next_s.dbg = io_wdata;
			else
				next_s.trim = io_wdata; // [RL14]
		end
		if (io_we && io_addr == alfio_pkg::IO_EVT_ADDR)
			evt_clr = io_wdata; // [RL9]
		// The 5-bit address cannot reach above 0x1F. [RL11]
		if (bit_valid) begin
			rmw_val = io_read({1'b0, bit_addr});
			rmw_val[bit_num] = bit_set;
			// Flags read as one go back as one and are cleared, unless bit_num clears them. [RL10]
			if ({1'b0, bit_addr} == alfio_pkg::IO_EVT_ADDR)
				evt_clr = evt_clr | rmw_val;
		end
		// A new event beats a clear in the same cycle.
		next_s.evt = (s.evt & ~evt_clr) | event_in; // [RL9]

		unique case (s.fsm)
			alfio_pkg::ST_IDLE: begin
				if (req_valid && alfio_pkg::is_word(req.op)) begin
					next_s.fsm = alfio_pkg::ST_WORD_HI; // [RL2] [RL6]
					next_s.lo = alu.res;
					next_s.carry = alu.c;
					next_s.word_sub = (req.op == alfio_pkg::OP_WORD_SUB_IMM);
					next_s.a_hi = req.a_hi;
				end else if (req_valid) begin
					next_s.result = {8'h00, alu.res};
					next_s.done = 1'b1;
					next_s.flags[alfio_pkg::FLAG_Z] = alu.z;
					next_s.flags[alfio_pkg::FLAG_N] = alu.n;
					if (alu_kind == alfio_pkg::KIND_AND ||
						alu_kind == alfio_pkg::KIND_OR) begin
						next_s.flags[alfio_pkg::FLAG_V] = 1'b0; // [RL7] [RL8] [RL15]
					end else begin
						next_s.flags[alfio_pkg::FLAG_V] = alu.v; // [RL1] [RL3]
						next_s.flags[alfio_pkg::FLAG_C] = alu.c; // [RL4] [RL5]
						next_s.flags[alfio_pkg::FLAG_H] = alu.h;
					end
				end
			end
			alfio_pkg::ST_WORD_HI: begin
				next_s.fsm = alfio_pkg::ST_IDLE;
				next_s.result = {alu.res, s.lo}; // [RL2] [RL6]
				next_s.done = 1'b1;
				next_s.flags[alfio_pkg::FLAG_Z] = (alu.res == 8'h00) &&
					(s.lo == 8'h00);
				next_s.flags[alfio_pkg::FLAG_C] = alu.c;
				next_s.flags[alfio_pkg::FLAG_N] = alu.n;
				next_s.flags[alfio_pkg::FLAG_V] = alu.v;
				next_s.flags[alfio_pkg::FLAG_S] = alu.n ^ alu.v;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			s <= STATE_RESET;
		else
			s <= next_s;
	end

	// Requests arriving during the high-byte cycle are not taken.
	assign req_ready = (s.fsm == alfio_pkg::ST_IDLE);
	assign result = s.result;
	assign result_valid = s.done;
	assign flag_register = s.flags;
	assign io_rdata = s.io_rdata;
	assign osc_trim = s.trim;
	assign debug_data = s.dbg;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	logic take;
	assign take = req_valid && req_ready;

	a_add_one_clock: assert property (@(posedge clk) disable iff (!rst_n) // [RL1]
		take && req.op == alfio_pkg::OP_ADD_REGS |=> result_valid &&
		result[7:0] == 8'($past(req.a) + $past(req.b)))
		else $error("add result wrong or late");

	a_word_add_two: assert property (@(posedge clk) disable iff (!rst_n) // [RL2]
		take && req.op == alfio_pkg::OP_WORD_ADD_IMM |=> !result_valid ##1
		(result_valid && result == 16'({$past(req.a_hi, 2), $past(req.a, 2)} +
		{8'h00, $past(req.b, 2)})))
		else $error("word add wrong or not two clocks");

	a_sub_carry: assert property (@(posedge clk) disable iff (!rst_n) // [RL3]
		take && req.op == alfio_pkg::OP_SUB_IMM && !io_we |=>
		flag_register[alfio_pkg::FLAG_C] == ($past(req.a) < $past(req.b)))
		else $error("subtract borrow flag wrong");

	a_sbc_regs_value: assert property (@(posedge clk) disable iff (!rst_n) // [RL4]
		take && req.op == alfio_pkg::OP_SUB_BORROW_REGS |=>
		result[7:0] == 8'($past(req.a) - $past(req.b) -
		$past(flag_register[alfio_pkg::FLAG_C])))
		else $error("subtract with carry result wrong");

	a_sbc_imm_zero: assert property (@(posedge clk) disable iff (!rst_n) // [RL5]
		take && req.op == alfio_pkg::OP_SUB_BORROW_IMM && !io_we |=>
		flag_register[alfio_pkg::FLAG_Z] == (result[7:0] == 8'h00))
		else $error("subtract with carry zero flag wrong");

	a_word_sub_two: assert property (@(posedge clk) disable iff (!rst_n) // [RL6]
		take && req.op == alfio_pkg::OP_WORD_SUB_IMM |=> ##1 result_valid &&
		result == 16'({$past(req.a_hi, 2), $past(req.a, 2)} -
		{8'h00, $past(req.b, 2)}))
		else $error("word subtract wrong");

	a_and_keeps_c: assert property (@(posedge clk) disable iff (!rst_n) // [RL7]
		take && req.op == alfio_pkg::OP_AND_IMM && !io_we |=>
		result[7:0] == $past(req.a & req.b) &&
		$stable(flag_register[alfio_pkg::FLAG_C]))
		else $error("and result or carry wrong");

	a_or_clears_v: assert property (@(posedge clk) disable iff (!rst_n) // [RL8] [RL15]
		take && req.op == alfio_pkg::OP_OR_REGS && !io_we |=>
		!flag_register[alfio_pkg::FLAG_V] &&
		$stable(flag_register[alfio_pkg::FLAG_H]))
		else $error("or flag handling wrong");

	a_evt_one_clears: assert property (@(posedge clk) disable iff (!rst_n) // [RL9]
		io_we && io_addr == alfio_pkg::IO_EVT_ADDR |=>
		(s.evt & $past(io_wdata & s.evt & ~event_in)) == 8'h00)
		else $error("write of one did not clear event flag");

	a_evt_zero_keeps: assert property (@(posedge clk) disable iff (!rst_n) // [RL9] [RL10]
		io_we && io_addr == alfio_pkg::IO_EVT_ADDR && !bit_valid |=>
		(s.evt & $past(s.evt & ~io_wdata)) == $past(s.evt & ~io_wdata))
		else $error("write of zero changed event flag");

	a_trim_select: assert property (@(posedge clk) disable iff (!rst_n) // [RL14]
		io_we && io_addr == alfio_pkg::IO_TRIM_ADDR && !debug_enable_fuse |=>
		osc_trim == $past(io_wdata) && $stable(debug_data))
		else $error("shared address did not select trim register");

	c_word_op: cover property (@(posedge clk) disable iff (!rst_n)
		take && alfio_pkg::is_word(req.op) ##2 result_valid);
	c_bit_clears: cover property (@(posedge clk) disable iff (!rst_n)
		bit_valid && {1'b0, bit_addr} == alfio_pkg::IO_EVT_ADDR && s.evt != 0);
	c_set_beats_clear: cover property (@(posedge clk) disable iff (!rst_n)
		io_we && io_addr == alfio_pkg::IO_EVT_ADDR && (io_wdata & event_in) != 0);
endmodule
